// File: include/spcd_pkg.sv
// constants for the smart panel command/data port
// assumes a 32-bit apb slave and an 18-line panel data bus
package spcd_pkg;
  localparam logic [31:0] ADDR_CONFIG = 32'h130500a0;
  localparam logic [31:0] ADDR_CONTROL = 32'h130500a4;
  localparam logic [31:0] ADDR_STATE = 32'h130500a8;
  localparam logic [31:0] ADDR_WORD = 32'h130500ac;
  localparam logic [31:0] ADDR_QUEUE = 32'h130500b0;
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'h130500b4;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h130500b8;
  localparam logic [31:0] RST_CONFIG = 32'h00000000;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h00000000;
  localparam logic [31:0] CONFIG_MASK = 32'h0000df9b;
  localparam logic [31:0] WORD_MASK = 32'h80ffffff;
  localparam int CFG_THRESH_LSB = 14;
  localparam int CFG_PIXW_LSB = 10;
  localparam int CFG_CMDW_LSB = 7;
  localparam int CFG_SEL_POL = 4;
  localparam int CFG_CMDSEL_POL = 3;
  localparam int CFG_CLK_POL = 1;
  localparam int CFG_LINK_TYPE = 0;
  localparam int CTRL_AUTO_EN = 0;
  localparam int WORD_FLAG = 31;
  localparam int IRQ_BITS = 2;
  localparam int IRQ_WORD_DONE = 0;
  localparam int IRQ_QUEUE_OVF = 1;
  localparam int QUEUE_DEPTH = 16;
  localparam int QUEUE_AW = 4;
  localparam logic [QUEUE_AW:0] THRESH_4 = 5'h04;
  localparam logic [QUEUE_AW:0] THRESH_8 = 5'h08;
  localparam logic [1:0] THRESH_CODE_4 = 2'h0;
  typedef enum logic [2:0] {
    SPCD_PW_18X1 = 3'h0, SPCD_PW_16X1 = 3'h1, SPCD_PW_8X3 = 3'h2,
    SPCD_PW_8X2 = 3'h3, SPCD_PW_8X1 = 3'h4, SPCD_PW_9X2 = 3'h7
  } spcd_pixw_t;
  typedef enum logic [1:0] {
    SPCD_CW_16 = 2'h0, SPCD_CW_8 = 2'h1, SPCD_CW_18 = 2'h2
  } spcd_cmdw_t;
  typedef enum logic [1:0] {
    SPCD_IDLE = 2'b00, SPCD_SETUP = 2'b01, SPCD_HOLD = 2'b11,
    SPCD_DONE = 2'b10
  } spcd_state_t;
endpackage

// File: hw/spcd_shifter.sv
// panel-side transfer engine: splits one word into beats and drives pins
// assumes pixTick is a one-cycle pulse per pixel clock rising edge
`timescale 1ns/1ps
module spcd_shifter (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic pixTick,
  input wire logic startReq,
  input wire logic startFlag,
  input wire logic [23:0] startPayload,
  input wire logic linkType,
  input wire logic clockEdgePolarity,
  input wire logic selectPolarity,
  input wire logic cmdselPolarity,
  input wire logic [2:0] pixelWidthSel,
  input wire logic [1:0] cmdWidthSel,
  output logic engineIdle,
  output logic wordDone,
  output logic cmdDataSelectPin,
  output logic panelSelectStrobe,
  output logic panelSerialClock,
  output logic [17:0] panelDataBus
);
  import spcd_pkg::*;
  spcd_state_t state, next_state;
  logic [1:0] beatIdx, next_beatIdx;
  logic [4:0] bitIdx, next_bitIdx;
  logic [23:0] payload, next_payload;
  logic flag, next_flag;
  logic next_wordDone, next_cmdDataSelectPin, next_panelSelectStrobe;
  logic next_panelSerialClock;
  logic [17:0] next_panelDataBus, beatData;

  // beats per word; reserved pixel width codes fall back to 18-bit single, reserved command width code to 16-bit
  function automatic logic [1:0] beatCount(input logic f,
                                           input logic [2:0] pw);
    if (f) return 2'd1;
    unique case (pw)
      SPCD_PW_8X3: return 2'd3;
      SPCD_PW_8X2, SPCD_PW_9X2: return 2'd2;
      default: return 2'd1;
    endcase
  endfunction

  function automatic logic [4:0] beatBits(input logic f, input logic [2:0] pw,
                                          input logic [1:0] cw);
    if (f) begin
      unique case (cw)
        SPCD_CW_8: return 5'd8;
        SPCD_CW_18: return 5'd18;
        default: return 5'd16;
      endcase
    end
    unique case (pw)
      SPCD_PW_16X1: return 5'd16;
      SPCD_PW_8X3, SPCD_PW_8X2, SPCD_PW_8X1: return 5'd8;
      SPCD_PW_9X2: return 5'd9;
      default: return 5'd18;
    endcase
  endfunction

  // right-aligned slice of the payload for one beat, first beat highest
  function automatic logic [17:0] sliceOf(input logic [23:0] p,
      input logic f, input logic [2:0] pw, input logic [1:0] cw,
      input logic [1:0] b);
    logic [4:0] n;
    n = beatBits(f, pw, cw);
    if (!f && pw == SPCD_PW_8X3) return {10'h000, p[23 - 8 * b -: 8]};
    if (!f && pw == SPCD_PW_8X2) return {10'h000, p[15 - 8 * b -: 8]};
    if (!f && pw == SPCD_PW_9X2) return {9'h000, p[17 - 9 * b -: 9]};
    return p[17:0] & ((18'h00001 << n) - 18'h00001);
  endfunction

  assign engineIdle = (state == SPCD_IDLE);
  assign beatData = sliceOf(payload, flag, pixelWidthSel, cmdWidthSel,
                            beatIdx);

  always_comb begin
    next_state = state;
    next_beatIdx = beatIdx;
    next_bitIdx = bitIdx;
    next_payload = payload;
    next_flag = flag;
    next_wordDone = 1'b0;
    unique case (state)
      SPCD_IDLE: if (startReq) begin
        next_payload = startPayload;
        next_flag = startFlag;
        next_beatIdx = 2'd0;
        next_bitIdx = beatBits(startFlag, pixelWidthSel, cmdWidthSel) - 5'd1;
        next_state = SPCD_SETUP;
      end
      SPCD_SETUP: if (pixTick) next_state = SPCD_HOLD;
      SPCD_HOLD: if (pixTick) begin
        if (linkType && bitIdx != 5'd0) begin
          next_bitIdx = bitIdx - 5'd1;
          next_state = SPCD_SETUP;
        end else if (beatIdx + 2'd1 < beatCount(flag, pixelWidthSel)) begin
          next_beatIdx = beatIdx + 2'd1;
          next_bitIdx = beatBits(flag, pixelWidthSel, cmdWidthSel) - 5'd1;
          next_state = SPCD_SETUP;
        end else begin
          next_state = SPCD_DONE;
        end
      end
      SPCD_DONE: if (pixTick) begin
        next_state = SPCD_IDLE;
        next_wordDone = 1'b1;
      end
    endcase
    // parallel: strobe pulses per beat, its trailing edge samples the bus
    next_panelSelectStrobe = (state != SPCD_IDLE &&
        (linkType ? state != SPCD_DONE : state == SPCD_SETUP))
        ? selectPolarity : ~selectPolarity;
    next_cmdDataSelectPin = ~((flag && state != SPCD_IDLE)
        ^ cmdselPolarity);
    next_panelSerialClock = (linkType && state == SPCD_SETUP)
        ? clockEdgePolarity : ~clockEdgePolarity;
    next_panelDataBus = 18'h00000;
    if (state == SPCD_SETUP || state == SPCD_HOLD) begin
      if (linkType) next_panelDataBus[15] = beatData[bitIdx];
      else next_panelDataBus = beatData;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state <= SPCD_IDLE;
      beatIdx <= 2'd0;
      bitIdx <= 5'd0;
      payload <= 24'h000000;
      flag <= 1'b0;
      wordDone <= 1'b0;
      cmdDataSelectPin <= 1'b1;
      panelSelectStrobe <= 1'b1;
      panelSerialClock <= 1'b1;
      panelDataBus <= 18'h00000;
    end else begin
      state <= next_state;
      beatIdx <= next_beatIdx;
      bitIdx <= next_bitIdx;
      payload <= next_payload;
      flag <= next_flag;
      wordDone <= next_wordDone;
      cmdDataSelectPin <= next_cmdDataSelectPin;
      panelSelectStrobe <= next_panelSelectStrobe;
      panelSerialClock <= next_panelSerialClock;
      panelDataBus <= next_panelDataBus;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_strobe_rest: assert property ($past(state) == SPCD_IDLE |->
      panelSelectStrobe == !$past(selectPolarity))
    else $error("strobe not at rest level while idle");
  a_select_flag: assert property ($past(state) == SPCD_SETUP |->
      cmdDataSelectPin == !($past(flag) ^ $past(cmdselPolarity)))
    else $error("select pin does not follow word flag");
  a_sclk_idle: assert property ($past(state) == SPCD_IDLE |->
      panelSerialClock == !$past(clockEdgePolarity))
    else $error("serial clock not idle");
  a_serial_line: assert property (linkType && $stable(linkType) |=>
      (panelDataBus & 18'h37fff) == 18'h00000)
    else $error("serial data left line 15");
  a_narrow_beat: assert property (!linkType && $past(!linkType) &&
      $past(beatBits(flag, pixelWidthSel, cmdWidthSel)) == 5'd8 |->
      panelDataBus[17:8] == 10'h000)
    else $error("unused data lines driven");
  a_sclk_parallel: assert property ($past(!linkType) |->
      panelSerialClock == !$past(clockEdgePolarity))
    else $error("serial clock moved in parallel mode");
endmodule

// File: hw/spcd_port.sv
// smart panel command/data port: apb registers, word queue, interrupt
// assumes an apb master on clock and a free pixel_clock from outside
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module spcd_port (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pixel_clock,
  output logic dmaReq,
  output logic irq,
  output logic cmdDataSelectPin,
  output logic panelSelectStrobe,
  output logic panelSerialClock,
  output logic [17:0] panelDataBus
);
  import spcd_pkg::*;
  logic [31:0] config_q, next_config;
  logic [7:0] control, next_control;
  logic [31:0] wordReg, next_wordReg;
  logic wordPending, next_wordPending;
  logic [IRQ_BITS-1:0] irqStatus, next_irqStatus;
  logic [IRQ_BITS-1:0] irqMask, next_irqMask;
  logic [31:0] next_prdata;
  logic [24:0] queueMem [QUEUE_DEPTH];
  logic [QUEUE_AW:0] wrPtr, next_wrPtr, rdPtr, next_rdPtr;
  logic [QUEUE_AW:0] fill, freeSlots, threshWords;
  logic pixSync1, pixSync2, pixSync3;
  logic pixTick, engineIdle, wordDone;
  logic writeEn, queuePush, queuePop, queueFull, queueEmpty, overflow;
  logic startReq, startFlag, busy, autoEn;
  logic [23:0] startPayload;

  function automatic logic isMapped(input logic [31:0] a);
    return a == ADDR_CONFIG || a == ADDR_CONTROL || a == ADDR_STATE ||
           a == ADDR_WORD || a == ADDR_QUEUE || a == ADDR_IRQ_STATUS ||
           a == ADDR_IRQ_MASK;
  endfunction

  // pixel clock is foreign: two flops, then a third for edge finding
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pixSync1 <= 1'b0;
      pixSync2 <= 1'b0;
      pixSync3 <= 1'b0;
    end else begin
      pixSync1 <= pixel_clock;
      pixSync2 <= pixSync1;
      pixSync3 <= pixSync2;
    end
  end
  assign pixTick = pixSync2 & ~pixSync3;

  assign autoEn = control[CTRL_AUTO_EN];
  assign fill = wrPtr - rdPtr;
  assign queueFull = (fill == 5'(QUEUE_DEPTH));
  assign queueEmpty = (wrPtr == rdPtr);
  assign freeSlots = 5'(QUEUE_DEPTH) - fill;
  // reserved threshold codes are treated as the larger request
  assign threshWords = (config_q[CFG_THRESH_LSB +: 2] == THRESH_CODE_4)
      ? THRESH_4 : THRESH_8;
  assign dmaReq = autoEn && freeSlots >= threshWords;
  assign busy = !engineIdle || wordPending ||
      (autoEn && !queueEmpty);

  // a pending register word goes first; the queue only while enabled
  assign startReq = engineIdle && (wordPending ||
      (autoEn && !queueEmpty));
  assign startFlag = wordPending ? wordReg[WORD_FLAG]
      : queueMem[rdPtr[QUEUE_AW-1:0]][24];
  assign startPayload = wordPending ? wordReg[23:0]
      : queueMem[rdPtr[QUEUE_AW-1:0]][23:0];
  assign queuePop = startReq && !wordPending;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !isMapped(paddr);
  assign writeEn = psel && penable && pwrite && isMapped(paddr);
  assign queuePush = writeEn && paddr == ADDR_QUEUE && !queueFull;
  assign overflow = writeEn && paddr == ADDR_QUEUE && queueFull;

  always_comb begin
    next_config = config_q;
    next_control = control;
    next_wordReg = wordReg;
    next_wordPending = wordPending && !startReq;
    next_irqMask = irqMask;
    next_irqStatus = irqStatus;
    if (writeEn) begin
      unique case (paddr)
        ADDR_CONFIG: next_config = pwdata & CONFIG_MASK;
        ADDR_CONTROL: next_control = pwdata[7:0] & 8'h01;
        ADDR_WORD: begin
          next_wordReg = pwdata & WORD_MASK;
          next_wordPending = 1'b1;
        end
        ADDR_IRQ_STATUS: next_irqStatus = irqStatus & ~pwdata[IRQ_BITS-1:0];
        ADDR_IRQ_MASK: next_irqMask = pwdata[IRQ_BITS-1:0];
        default: ;
      endcase
    end
    // a fresh event wins over a clear in the same cycle
    next_irqStatus[IRQ_WORD_DONE] = next_irqStatus[IRQ_WORD_DONE] | wordDone;
    next_irqStatus[IRQ_QUEUE_OVF] = next_irqStatus[IRQ_QUEUE_OVF] | overflow;
    // read data is latched in the setup cycle so it comes from a flop
    next_prdata = prdata;
    if (psel && !penable) begin
      unique case (paddr)
        ADDR_CONFIG: next_prdata = config_q;
        ADDR_CONTROL: next_prdata = {24'h000000, control};
        ADDR_STATE: next_prdata = {31'h00000000, busy};
        ADDR_WORD: next_prdata = wordReg;
        ADDR_QUEUE: next_prdata = {queueMem[rdPtr[QUEUE_AW-1:0]][24],
            7'h00, queueMem[rdPtr[QUEUE_AW-1:0]][23:0]};
        ADDR_IRQ_STATUS: next_prdata = {30'h00000000, irqStatus};
        ADDR_IRQ_MASK: next_prdata = {30'h00000000, irqMask};
        default: next_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      config_q <= RST_CONFIG;
      control <= RST_CONTROL;
      wordReg <= RST_WORD;
      wordPending <= 1'b0;
      irqStatus <= '0;
      irqMask <= '0;
      prdata <= 32'h00000000;
      irq <= 1'b0;
    end else begin
      config_q <= next_config;
      control <= next_control;
      wordReg <= next_wordReg;
      wordPending <= next_wordPending;
      irqStatus <= next_irqStatus;
      irqMask <= next_irqMask;
      prdata <= next_prdata;
      irq <= |(next_irqStatus & next_irqMask);
    end
  end

  always_comb begin
    next_wrPtr = wrPtr + 5'(queuePush);
    next_rdPtr = rdPtr + 5'(queuePop);
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
    end
  end

  // storage has no reset; an ADDR_QUEUE read while empty returns the stale or unwritten entry at rdPtr
  always_ff @(posedge clock) begin
    if (queuePush)
      queueMem[wrPtr[QUEUE_AW-1:0]] <= {pwdata[WORD_FLAG],
          pwdata[23:0]};
  end

  spcd_shifter engine (
    .clock(clock),
    .sys_rst(sys_rst),
    .pixTick(pixTick),
    .startReq(startReq),
    .startFlag(startFlag),
    .startPayload(startPayload),
    .linkType(config_q[CFG_LINK_TYPE]),
    .clockEdgePolarity(config_q[CFG_CLK_POL]),
    .selectPolarity(config_q[CFG_SEL_POL]),
    .cmdselPolarity(config_q[CFG_CMDSEL_POL]),
    .pixelWidthSel(config_q[CFG_PIXW_LSB +: 3]),
    .cmdWidthSel(config_q[CFG_CMDW_LSB +: 2]),
    .engineIdle(engineIdle),
    .wordDone(wordDone),
    .cmdDataSelectPin(cmdDataSelectPin),
    .panelSelectStrobe(panelSelectStrobe),
    .panelSerialClock(panelSerialClock),
    .panelDataBus(panelDataBus)
  );

  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_dma_threshold: assert property (dmaReq |->
      freeSlots >= ((config_q[15:14] == 2'b00) ? 5'd4 : 5'd8))
    else $error("dma request below threshold space");
  a_busy_word: assert property (writeEn && paddr == ADDR_WORD |=>
      busy [*2])
    else $error("busy low right after a word write");
  a_state_read: assert property (psel && !penable &&
      paddr == ADDR_STATE |=> prdata[31:1] == 31'h0 && prdata[0] == $past(busy))
    else $error("status read shows wrong bits");
  a_auto_start: assert property (autoEn && engineIdle && !queueEmpty &&
      !wordPending |=> !engineIdle && rdPtr == $past(rdPtr) + 5'd1)
    else $error("queued word not taken while enabled");
  a_word_flag: assert property (writeEn && paddr == ADDR_WORD |=>
      wordReg[30:24] == 7'h00 && wordReg[31] == $past(pwdata[31]))
    else $error("word register flag or reserved bits wrong");
  a_irq_sticky: assert property (wordDone |=> irqStatus[IRQ_WORD_DONE])
    else $error("done event lost");
  a_cfg_reserved: assert property (writeEn &&
      paddr == ADDR_CONFIG |=> config_q[13] == 1'b0 &&
      config_q[6:5] == 2'b00 && config_q[2] == 1'b0)
    else $error("reserved config bit stored");
  a_word_start: assert property (wordPending && engineIdle |=>
      !engineIdle && !wordPending)
    else $error("pending word not started");
  a_queue_hold: assert property (!$past(autoEn) |->
      rdPtr == $past(rdPtr))
    else $error("queue popped while auto transfer off");
endmodule

// File: testbench/spcd_panel_model.sv
// display module stand-in: records what the port puts on the panel pins
// assumes pins are registered on clock, so sampling on clock is exact
`timescale 1ns/1ps
module spcd_panel_model (
  input wire logic clock,
  input wire logic clr,
  input wire logic selPol,
  input wire logic clkPol,
  input wire logic serial,
  input wire logic cmdDataSelectPin,
  input wire logic panelSelectStrobe,
  input wire logic panelSerialClock,
  input wire logic [17:0] panelDataBus,
  output logic [31:0] nBeats,
  output logic [31:0] nBits,
  output logic [23:0] serWord,
  output logic [17:0] lastBeat,
  output logic lastSel,
  output logic stray
);
  logic [17:0] beat [3];
  logic prevStb;
  logic prevClk;
  logic act;
  assign act = (panelSelectStrobe == selPol);
  always @(posedge clock) begin
    prevStb <= panelSelectStrobe;
    prevClk <= panelSerialClock;
    if (clr) begin
      nBeats <= 0;
      nBits <= 0;
      serWord <= 24'h0;
      stray <= 1'b0;
    end else if (!serial) begin
      // the module latches the bus only on the strobe's trailing edge
      if (prevStb == selPol && !act) begin
        if (nBeats < 3) beat[nBeats[1:0]] <= panelDataBus;
        lastBeat <= panelDataBus;
        lastSel <= cmdDataSelectPin;
        nBeats <= nBeats + 1;
      end
    end else if (act) begin
      if ((panelDataBus & 18'h37fff) != 18'h0) stray <= 1'b1;
      // sample on the edge opposite the launch edge
      if (prevClk != panelSerialClock && panelSerialClock != clkPol) begin
        serWord <= {serWord[22:0], panelDataBus[15]};
        nBits <= nBits + 1;
        lastSel <= cmdDataSelectPin;
      end
    end
  end
endmodule

// File: testbench/spcd_port_tb_top.sv
// self-checking bench: apb master tasks, panel model, polled busy
// assumes zero or more wait states; pixel clock free-running at 160 ns
`timescale 1ns/1ps
module spcd_port_tb_top;
  import spcd_pkg::*;
  logic clock, sys_rst, psel, penable, pwrite, pixel_clock;
  logic [31:0] paddr, pwdata, prdata;
  logic pready, pslverr, dmaReq, irq;
  logic cmdDataSelectPin, panelSelectStrobe, panelSerialClock;
  logic [17:0] panelDataBus, sBus, mLast;
  logic clr, mSel, mClk, mSer, sIrq, sReq, sStb, sSel, sClk, mLastSel, mStray;
  logic [31:0] mBeats, mBits;
  logic [23:0] mWord;
  int n_mismatch, checks;
  localparam logic [23:0] PAY = 24'habcdef;
  logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  int nbt [6] = '{1, 1, 3, 2, 1, 2};
  logic [31:0] rstA [5] = '{ADDR_CONFIG, ADDR_CONTROL, ADDR_STATE,
    ADDR_WORD, ADDR_IRQ_MASK};

  spcd_port DUT (.clock(clock), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pixel_clock(pixel_clock), .dmaReq(dmaReq), .irq(irq),
    .cmdDataSelectPin(cmdDataSelectPin),
    .panelSelectStrobe(panelSelectStrobe),
    .panelSerialClock(panelSerialClock), .panelDataBus(panelDataBus));
  spcd_panel_model pm (.clock(clock), .clr(clr), .selPol(mSel),
    .clkPol(mClk), .serial(mSer), .cmdDataSelectPin(cmdDataSelectPin),
    .panelSelectStrobe(panelSelectStrobe),
    .panelSerialClock(panelSerialClock), .panelDataBus(panelDataBus),
    .nBeats(mBeats), .nBits(mBits), .serWord(mWord), .lastBeat(mLast),
    .lastSel(mLastSel), .stray(mStray));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // pixel clock phase is deliberately unrelated to the system clock
  initial begin
    pixel_clock = 1'b0;
    #37;
    forever #80 pixel_clock = ~pixel_clock;
  end
  // levels are sampled mid-cycle so they are settled
  always @(negedge clock) begin
    sIrq <= irq;
    sReq <= dmaReq;
    sStb <= panelSelectStrobe;
    sSel <= cmdDataSelectPin;
    sClk <= panelSerialClock;
    sBus <= panelDataBus;
  end

  task check(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // no wait-state count is assumed; only the watchdog ends this wait
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask
  task automatic wait_idle;
    logic [31:0] r;
    int n;
    n = 0;
    do begin
      rd(ADDR_STATE, r);
      n++;
    end while (r[0] !== 1'b0 && n < 500);
    if (r[0] !== 1'b0) check("busy wait", 32'h1, 32'h0);
  endtask
  task cfg(input logic [31:0] v);
    wr(ADDR_CONFIG, v);
    mSel <= v[4];
    mClk <= v[1];
    mSer <= v[0];
  endtask
  task automatic send(input logic f, input logic [23:0] p);
    logic [31:0] r;
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    wr(ADDR_WORD, {f, 7'h7f, p});
    rd(ADDR_STATE, r);
    check("busy", r & 32'h1, 32'h1);
    wait_idle;
  endtask
  function automatic logic [17:0] expBeat(input logic [2:0] c, input int j,
      input logic [23:0] p);
    case (c)
      3'h0: return p[17:0];
      3'h1: return {2'h0, p[15:0]};
      3'h2: return {10'h0, p[23-8*j -: 8]};
      3'h3: return {10'h0, p[15-8*j -: 8]};
      3'h7: return (j == 0) ? {9'h0, p[17:9]} : {9'h0, p[8:0]};
      default: return {10'h0, p[7:0]};
    endcase
  endfunction

  initial begin
    #1500000;
    check("watchdog", 32'h1, 32'h0);
    wrap_up;
  end

  initial begin
    logic [31:0] r;
    logic e;
    logic [1:0] cw;
    sys_rst = 1'b1;
    {psel, penable, pwrite, clr, mSel, mClk, mSer} = 7'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    n_mismatch = 0;
    checks = 0;
    repeat (2) @(posedge clock);
    check("rest strobe", 32'(sStb), 32'h1);
    check("rest select", 32'(sSel), 32'h1);
    check("rest bus", 32'(sBus), 32'h0);
    sys_rst <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 5; i++) begin
      rd(rstA[i], r);
      check("reset value", r, 32'h0);
    end
    wr(ADDR_CONFIG, 32'hffffffff);
    rd(ADDR_CONFIG, r);
    check("config bits", r, CONFIG_MASK);
    wr(ADDR_STATE, 32'hffffffff);
    rd(ADDR_STATE, r);
    check("state write", r, 32'h0);
    cfg(32'h0);
    send(1'b0, 24'h00ff12);
    rd(ADDR_WORD, r);
    check("word bits", r, 32'h0000ff12);
    apb(1'b0, ADDR_IRQ_MASK + 32'h4, 32'h0, r, e);
    check("unmapped err", 32'(e), 32'h1);
    check("unmapped data", r, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      cw = (codes[i] == 3'h0) ? 2'h2 : (codes[i] == 3'h1 ||
        codes[i] == 3'h7) ? 2'h0 : 2'h1;
      cfg((32'(codes[i]) << 10) | (32'(cw) << 7));
      send(1'b0, PAY);
      check("data beats", mBeats, nbt[i]);
      for (int j = 0; j < nbt[i]; j++)
        check("data beat", 32'(pm.beat[j]), 32'(expBeat(codes[i], j, PAY)));
      check("data select", 32'(mLastSel), 32'h1);
      send(1'b1, PAY);
      check("cmd beats", mBeats, 32'h1);
      check("cmd beat", 32'(mLast), (cw == 2'h2) ? 32'h3cdef :
        (cw == 2'h0) ? 32'hcdef : 32'hef);
      check("cmd select", 32'(mLastSel), 32'h0);
    end
    $display("test widths done");
    cfg(32'h1098);
    // the strobe pin moves one edge after the config write lands
    @(posedge clock);
    check("rest strobe high", 32'(sStb), 32'h0);
    send(1'b1, PAY);
    check("cmd select inv", 32'(mLastSel), 32'h1);
    check("strobe high beat", 32'(mLast), 32'hef);
    send(1'b0, PAY);
    check("data select inv", 32'(mLastSel), 32'h0);
    $display("test polarity done");
    for (int k = 0; k < 2; k++) begin
      cfg(32'h401 | (32'(k) << 1));
      send(1'b0, 24'h00a5c3);
      check("serial bits", mBits, 32'd16);
      check("serial word", 32'(mWord[15:0]), 32'ha5c3);
      check("serial lines", 32'(mStray), 32'h0);
      check("clock rest", 32'(sClk), 32'(k == 0));
    end
    $display("test serial done");
    cfg(32'h1080);
    wr(ADDR_IRQ_STATUS, 32'h3);
    wr(ADDR_IRQ_MASK, 32'h1);
    send(1'b0, PAY);
    check("irq raised", 32'(sIrq), 32'h1);
    wr(ADDR_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge clock);
    check("irq cleared", 32'(sIrq), 32'h0);
    wr(ADDR_IRQ_MASK, 32'h0);
    send(1'b0, PAY);
    check("irq masked", 32'(sIrq), 32'h0);
    rd(ADDR_IRQ_STATUS, r);
    check("irq status", r & 32'h1, 32'h1);
    $display("test interrupt done");
    send(1'b0, PAY);
    for (int i = 0; i < 10; i++) wr(ADDR_QUEUE, 32'hff0000e0 + i);
    check("req auto off", 32'(sReq), 32'h0);
    rd(ADDR_QUEUE, r);
    check("queue head", r, 32'h800000e0);
    // the register word sent above must not count as a queued beat
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    wr(ADDR_CONTROL, 32'h1);
    check("req 4 words", 32'(sReq), 32'h1);
    wr(ADDR_CONFIG, 32'h5080);
    check("req 8 words", 32'(sReq), 32'h0);
    wait_idle;
    check("queued beats", mBeats, 32'd10);
    check("queued last", 32'(mLast), 32'he9);
    check("queued select", 32'(mLastSel), 32'h0);
    check("req empty", 32'(sReq), 32'h1);
    wr(ADDR_CONTROL, 32'h0);
    check("req stopped", 32'(sReq), 32'h0);
    clr <= 1'b1;
    repeat (32) @(posedge clock);
    clr <= 1'b0;
    wr(ADDR_QUEUE, 32'h0000005a);
    check("held while off", 32'(sReq), 32'h0);
    wr(ADDR_CONTROL, 32'h1);
    wait_idle;
    check("restart beats", mBeats, 32'd1);
    check("restart beat", 32'(mLast), 32'h5a);
    check("restart select", 32'(mLastSel), 32'h1);
    $display("test queue done");
    wrap_up;
  end
endmodule
